// ### hw/fbmp_pkg.sv
// constants and types for the framebuffer memory port
package fbmp_pkg;
  localparam int DATA_W = 128;
  localparam int LANES = 16;
  localparam int ADDR_W = 11;
  localparam int STRAP_W = 11;
  localparam int ROM_BYTE_W = 8;
  localparam int ROM_ADDR_W = 16;
  // shared data line positions used by boot store cycles
  localparam int ROM_ADDR_LSB = 0;
  localparam int ROM_OE_BIT = 16;
  localparam int ROM_WE_BIT = 17;
  localparam int ROM_BYTE_LSB = 24;
  localparam int ROM_DRIVE_W = 18;
  // strap field: bit set selects sdram, clear selects sgram
  localparam int STRAP_SDRAM_BIT = 0;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 11'h000;
  // timing
  localparam int CORE_CLK_MHZ = 125;
  localparam int ROM_ACCESS_NS = 120;
  localparam int ROM_WAIT_CYC = (ROM_ACCESS_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [4:0] ROM_WAIT = 5'(ROM_WAIT_CYC + 2);
  localparam logic [1:0] CAS_LAT = 2'h2;
  // row, column, write strobe codes, active low
  localparam logic [2:0] STB_NOP = 3'h7;
  localparam logic [2:0] STB_ACT = 3'h3;
  localparam logic [2:0] STB_RD = 3'h5;
  localparam logic [2:0] STB_WR = 3'h4;
  localparam logic [2:0] STB_PRE = 3'h2;
  localparam logic [2:0] STB_REF = 3'h1;
  localparam logic [2:0] STB_MRS = 3'h0;

  typedef enum logic [3:0] {
    FBMP_CMD_NOP = 4'h0,
    FBMP_CMD_ACT = 4'h1,
    FBMP_CMD_RD = 4'h2,
    FBMP_CMD_WR = 4'h3,
    FBMP_CMD_PRE = 4'h4,
    FBMP_CMD_REF = 4'h5,
    FBMP_CMD_MRS = 4'h6,
    FBMP_CMD_ROM_RD = 4'h7,
    FBMP_CMD_ROM_WR = 4'h8
  } fbmp_cmd_t;

  typedef enum logic [4:0] {
    FBMP_ST_IDLE = 5'h01,
    FBMP_ST_ALIGN = 5'h02,
    FBMP_ST_HOLD = 5'h04,
    FBMP_ST_ROM = 5'h08,
    FBMP_ST_RDW = 5'h10
  } fbmp_state_t;

  function automatic logic [2:0] fbmp_strobes(input fbmp_cmd_t cmd);
    case (cmd)
      FBMP_CMD_ACT: fbmp_strobes = STB_ACT;
      FBMP_CMD_RD: fbmp_strobes = STB_RD;
      FBMP_CMD_WR: fbmp_strobes = STB_WR;
      FBMP_CMD_PRE: fbmp_strobes = STB_PRE;
      FBMP_CMD_REF: fbmp_strobes = STB_REF;
      FBMP_CMD_MRS: fbmp_strobes = STB_MRS;
      default: fbmp_strobes = STB_NOP;
    endcase
  endfunction

  function automatic logic fbmp_is_rom(input fbmp_cmd_t cmd);
    fbmp_is_rom = (cmd == FBMP_CMD_ROM_RD) || (cmd == FBMP_CMD_ROM_WR);
  endfunction
endpackage

// ### hw/fbmp_port.sv
// framebuffer memory port: sdram/sgram pins, boot store cycles, strap capture
//
// Behaviour
// - 128-bit two-way data bus to all framebuffer memories for reads and writes.
// - boot store cycles reuse data lines: address, byte, write and output strobes.
// - drive 11-bit address bus; sample straps on it while host reset holds.
// - single shared active-low row, column and write strobes for all memories.
// - two active-low chip selects; with sdram the upper carries the bank bit.
// - sixteen byte mask strobes, one per data byte lane.
// - separate memory clock output for each bank.
// - third clock loops back externally as capture clock for read data.
// - drive memory clock enable.
// - active-low boot store select during boot store cycles.
`timescale 1ns/100ps
module fbmp_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mem_clk_return_i,
  input wire logic host_reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire fbmp_pkg::fbmp_cmd_t req_cmd_i,
  input wire logic [fbmp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic req_bank_i,
  input wire logic req_chip_i,
  input wire logic [fbmp_pkg::ROM_ADDR_W-1:0] req_rom_addr_i,
  input wire logic [fbmp_pkg::ROM_BYTE_W-1:0] req_rom_byte_i,
  input wire logic [fbmp_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic [fbmp_pkg::LANES-1:0] req_byte_en_i,
  input wire logic clk_en_req_i,
  output logic [fbmp_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic [fbmp_pkg::ROM_BYTE_W-1:0] rom_byte_o,
  output logic rom_valid_o,
  output logic [fbmp_pkg::STRAP_W-1:0] strap_o,
  input wire logic [fbmp_pkg::DATA_W-1:0] fb_data_i,
  output logic [fbmp_pkg::DATA_W-1:0] fb_data_o,
  output logic [fbmp_pkg::DATA_W-1:0] fb_data_oe_o,
  input wire logic [fbmp_pkg::ADDR_W-1:0] mem_addr_i,
  output logic [fbmp_pkg::ADDR_W-1:0] mem_addr_o,
  output logic mem_addr_oe_o,
  output logic mem_row_strobe_n_o,
  output logic mem_col_strobe_n_o,
  output logic mem_write_n_o,
  output logic [1:0] mem_select_n_o,
  output logic [fbmp_pkg::LANES-1:0] mem_byte_mask_o,
  output logic mem_clk_bank0_o,
  output logic mem_clk_bank1_o,
  output logic mem_clk_loop_o,
  output logic mem_clk_en_o,
  output logic boot_store_select_n_o
);
  import fbmp_pkg::*;

  fbmp_state_t state_reg, state_next;
  fbmp_cmd_t cmd_reg;
  logic phase_reg, clk0_reg, clk1_reg, loop_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic bank_reg, chip_reg;
  logic [ROM_ADDR_W-1:0] rom_addr_reg;
  logic [ROM_BYTE_W-1:0] rom_wbyte_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [LANES-1:0] en_reg;
  logic ready_reg;
  logic [4:0] cnt_reg;
  logic hrst_s1_reg, hrst_s2_reg;
  logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg, strap_reg;
  logic [ROM_BYTE_W-1:0] romb_s1_reg, romb_s2_reg, rom_byte_reg;
  logic rom_valid_reg;
  logic [DATA_W-1:0] fbd_reg, fbd_oe_reg, rd_data_reg;
  logic rd_valid_reg;
  logic [ADDR_W-1:0] maddr_reg;
  logic maddr_oe_reg;
  logic [2:0] stb_reg;
  logic [1:0] sel_n_reg;
  logic [LANES-1:0] mask_reg;
  logic cke_reg, rom_sel_n_reg;
  logic rd_tgl_reg, ack_s1_reg, ack_s2_reg, ack_seen_reg;
  // link side, clocked by the looped-back memory clock
  logic rq_s1_reg, rq_s2_reg, rq_seen_reg, ack_tgl_reg;
  logic [1:0] lat_reg;
  logic [DATA_W-1:0] cap_reg;

  // command edge: pins change as the memory clock falls, memory samples on rise
  wire fall_edge = phase_reg;
  wire accept = (state_reg == FBMP_ST_IDLE) && ready_reg && req_valid_i;
  wire sdram_mode = strap_reg[STRAP_SDRAM_BIT];
  wire is_rom = fbmp_is_rom(cmd_reg);
  wire is_wr = (cmd_reg == FBMP_CMD_WR);
  wire rom_wr = (cmd_reg == FBMP_CMD_ROM_WR);
  wire ack_new = (ack_s2_reg != ack_seen_reg);
  wire drive_cmd = (state_reg == FBMP_ST_ALIGN) && fall_edge;
  wire end_cmd = (state_reg == FBMP_ST_HOLD) && fall_edge;
  wire rom_done = (state_reg == FBMP_ST_ROM) && (cnt_reg == 5'h00);
  wire [1:0] sel_n_cmd = sdram_mode ? {bank_reg, 1'b0} : (chip_reg ? 2'h1 : 2'h2);
  wire [DATA_W-1:0] rom_lines = {{(DATA_W-32){1'b0}}, rom_wbyte_reg, 6'h00, rom_wr ? 1'b0 : 1'b1,
                                 rom_wr ? 1'b1 : 1'b0, rom_addr_reg};
  wire [DATA_W-1:0] rom_oe = rom_wr ? {{(DATA_W-32){1'b0}}, 8'hFF, 6'h00, {ROM_DRIVE_W{1'b1}}}
                                    : {{(DATA_W-ROM_DRIVE_W){1'b0}}, {ROM_DRIVE_W{1'b1}}};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FBMP_ST_IDLE: if (accept) state_next = FBMP_ST_ALIGN;
      FBMP_ST_ALIGN: if (fall_edge) state_next = is_rom ? FBMP_ST_ROM : FBMP_ST_HOLD;
      FBMP_ST_HOLD: if (fall_edge) state_next = (cmd_reg == FBMP_CMD_RD) ? FBMP_ST_RDW : FBMP_ST_IDLE;
      FBMP_ST_ROM: if (cnt_reg == 5'h00) state_next = FBMP_ST_IDLE;
      FBMP_ST_RDW: if (ack_new) state_next = FBMP_ST_IDLE;
      default: state_next = FBMP_ST_IDLE;
    endcase
  end

  // memory clocks, one flop each so each bank load sees its own driver
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 1'b0;
      clk0_reg <= 1'b0;
      clk1_reg <= 1'b0;
      loop_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      clk0_reg <= ~phase_reg;
      clk1_reg <= ~phase_reg;
      loop_reg <= ~phase_reg;
    end
  end

  // host reset and strap synchronisers; straps follow the lines only in reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrst_s1_reg <= 1'b0;
      hrst_s2_reg <= 1'b0;
      strap_s1_reg <= STRAP_RESET;
      strap_s2_reg <= STRAP_RESET;
      strap_reg <= STRAP_RESET;
      romb_s1_reg <= '0;
      romb_s2_reg <= '0;
    end else begin
      hrst_s1_reg <= host_reset_n_i;
      hrst_s2_reg <= hrst_s1_reg;
      strap_s1_reg <= mem_addr_i;
      strap_s2_reg <= strap_s1_reg;
      if (!hrst_s2_reg) strap_reg <= strap_s2_reg;
      romb_s1_reg <= fb_data_i[ROM_BYTE_LSB +: ROM_BYTE_W];
      romb_s2_reg <= romb_s1_reg;
    end
  end

  // request capture and sequencing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= FBMP_ST_IDLE;
      cmd_reg <= FBMP_CMD_NOP;
      addr_reg <= '0;
      bank_reg <= 1'b0;
      chip_reg <= 1'b0;
      rom_addr_reg <= '0;
      rom_wbyte_reg <= '0;
      wdata_reg <= '0;
      en_reg <= '0;
      ready_reg <= 1'b0;
      cnt_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      // one access at a time, and none while host reset holds
      ready_reg <= (state_next == FBMP_ST_IDLE) && hrst_s2_reg;
      if (accept) begin
        cmd_reg <= req_cmd_i;
        addr_reg <= req_addr_i;
        bank_reg <= req_bank_i;
        chip_reg <= req_chip_i;
        rom_addr_reg <= req_rom_addr_i;
        rom_wbyte_reg <= req_rom_byte_i;
        wdata_reg <= req_wdata_i;
        en_reg <= req_byte_en_i;
      end
      if (drive_cmd) cnt_reg <= ROM_WAIT;
      else if (cnt_reg != 5'h00) cnt_reg <= cnt_reg - 5'h01;
    end
  end

  // memory pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      maddr_reg <= '0;
      maddr_oe_reg <= 1'b0;
      stb_reg <= STB_NOP;
      sel_n_reg <= 2'h3;
      mask_reg <= '0;
      fbd_reg <= '0;
      fbd_oe_reg <= '0;
      rom_sel_n_reg <= 1'b1;
      cke_reg <= 1'b0;
    end else begin
      maddr_oe_reg <= hrst_s2_reg;
      cke_reg <= hrst_s2_reg && clk_en_req_i;
      if (drive_cmd && is_rom) begin
        fbd_reg <= rom_lines;
        fbd_oe_reg <= rom_oe;
        rom_sel_n_reg <= 1'b0;
      end else if (drive_cmd) begin
        maddr_reg <= addr_reg;
        stb_reg <= fbmp_strobes(cmd_reg);
        sel_n_reg <= sel_n_cmd;
        mask_reg <= is_wr ? ~en_reg : '0;
        fbd_reg <= wdata_reg;
        fbd_oe_reg <= is_wr ? {DATA_W{1'b1}} : '0;
      end else if (end_cmd || rom_done) begin
        // release strobes, selects, masks, data drive and boot store select; the address keeps its last value
        stb_reg <= STB_NOP;
        sel_n_reg <= 2'h3;
        mask_reg <= '0;
        fbd_oe_reg <= '0;
        rom_sel_n_reg <= 1'b1;
      end
    end
  end

  // results and read handshake, core side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_byte_reg <= '0;
      rom_valid_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      rom_valid_reg <= rom_done && !rom_wr;
      if (rom_done && !rom_wr) rom_byte_reg <= romb_s2_reg;
      if (end_cmd && cmd_reg == FBMP_CMD_RD) rd_tgl_reg <= ~rd_tgl_reg;
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      rd_valid_reg <= (state_reg == FBMP_ST_RDW) && ack_new;
      if ((state_reg == FBMP_ST_RDW) && ack_new) begin
        ack_seen_reg <= ack_s2_reg;
        // capture word is held stable until the next read toggle
        rd_data_reg <= cap_reg;
      end
    end
  end

  // link side: read data is taken on the returned clock, which tracks board delay
  always_ff @(posedge mem_clk_return_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rq_s1_reg <= 1'b0;
      rq_s2_reg <= 1'b0;
      rq_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      lat_reg <= 2'h0;
      cap_reg <= '0;
    end else begin
      rq_s1_reg <= rd_tgl_reg;
      rq_s2_reg <= rq_s1_reg;
      if (rq_s2_reg != rq_seen_reg) begin
        if (lat_reg == CAS_LAT - 2'h1) begin
          cap_reg <= fb_data_i;
          ack_tgl_reg <= ~ack_tgl_reg;
          rq_seen_reg <= rq_s2_reg;
          lat_reg <= 2'h0;
        end else begin
          lat_reg <= lat_reg + 2'h1;
        end
      end
    end
  end

  assign req_ready_o = ready_reg;
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign rom_byte_o = rom_byte_reg;
  assign rom_valid_o = rom_valid_reg;
  assign strap_o = strap_reg;
  assign fb_data_o = fbd_reg;
  assign fb_data_oe_o = fbd_oe_reg;
  assign mem_addr_o = maddr_reg;
  assign mem_addr_oe_o = maddr_oe_reg;
  assign mem_row_strobe_n_o = stb_reg[2];
  assign mem_col_strobe_n_o = stb_reg[1];
  assign mem_write_n_o = stb_reg[0];
  assign mem_select_n_o = sel_n_reg;
  assign mem_byte_mask_o = mask_reg;
  assign mem_clk_bank0_o = clk0_reg;
  assign mem_clk_bank1_o = clk1_reg;
  assign mem_clk_loop_o = loop_reg;
  assign mem_clk_en_o = cke_reg;
  assign boot_store_select_n_o = rom_sel_n_reg;
endmodule

// ### testbench/fbmp_port_assertions.sv
// concurrent checks on the framebuffer memory port pins
`timescale 1ns/100ps
module fbmp_port_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic host_reset_n_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic clk_en_req_i,
  input wire logic [10:0] strap_o,
  input wire logic [127:0] fb_data_o,
  input wire logic [127:0] fb_data_oe_o,
  input wire logic mem_addr_oe_o,
  input wire logic mem_row_strobe_n_o,
  input wire logic mem_col_strobe_n_o,
  input wire logic mem_write_n_o,
  input wire logic [1:0] mem_select_n_o,
  input wire logic [15:0] mem_byte_mask_o,
  input wire logic mem_clk_bank0_o,
  input wire logic mem_clk_bank1_o,
  input wire logic mem_clk_loop_o,
  input wire logic mem_clk_en_o,
  input wire logic boot_store_select_n_o
);
  import fbmp_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [2:0] stb = {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_n_o};
  wire busy = stb != STB_NOP;
  wire rom_on = !boot_store_select_n_o;
  sequence s_cmd_start; busy && $past(stb) == STB_NOP; endsequence
  sequence s_cmd_end; $stable(stb) ##1 !busy; endsequence
  property p_cmd_stand; s_cmd_start |=> s_cmd_end; endproperty
  a_cmd_stand: assert property (p_cmd_stand) else $error("command strobes did not stand one memory clock");
  property p_sel; stb == STB_RD || stb == STB_WR |-> (strap_o[0] ? !mem_select_n_o[0] : ^mem_select_n_o); endproperty
  a_sel: assert property (p_sel) else $error("chip select wrong for fitted memory");
  property p_drive; |fb_data_oe_o |-> stb == STB_WR || rom_on; endproperty
  a_drive: assert property (p_drive) else $error("data lines driven outside write or boot store");
  property p_overlap; rom_on |-> !busy; endproperty
  a_overlap: assert property (p_overlap) else $error("boot store cycle overlaps memory command");
  property p_wr; stb == STB_WR |-> &fb_data_oe_o; endproperty
  a_wr: assert property (p_wr) else $error("write data not driven");
  property p_rd; stb == STB_RD |-> mem_byte_mask_o == 16'h0000 && !(|fb_data_oe_o); endproperty
  a_rd: assert property (p_rd) else $error("read masked or data driven");
  property p_rom_lines; rom_on |-> &fb_data_oe_o[17:0] && fb_data_o[17] != fb_data_o[16]; endproperty
  a_rom_lines: assert property (p_rom_lines) else $error("boot store lines wrong");
  property p_rom_stand; $fell(boot_store_select_n_o) |-> ##17 rom_on ##1 !rom_on; endproperty
  a_rom_stand: assert property (p_rom_stand) else $error("boot store select length wrong");
  // two sync stages plus the output flop: the pin must have been low four samples
  property p_host_rst; (!host_reset_n_i) [*4] |-> !req_ready_o && !mem_addr_oe_o && !mem_clk_en_o; endproperty
  a_host_rst: assert property (p_host_rst) else $error("active during host reset");
  property p_cke; host_reset_n_i [*5] |-> mem_clk_en_o == $past(clk_en_req_i); endproperty
  a_cke: assert property (p_cke) else $error("clock enable does not follow request");
  property p_strap; host_reset_n_i [*5] |-> $stable(strap_o); endproperty
  a_strap: assert property (p_strap) else $error("straps moved after host reset");
  property p_clk; mem_clk_bank0_o |-> mem_clk_bank1_o && mem_clk_loop_o ##1 !mem_clk_bank0_o; endproperty
  a_clk: assert property (p_clk) else $error("memory clocks out of step");
  property p_one; req_valid_i && req_ready_o |=> !req_ready_o; endproperty
  a_one: assert property (p_one) else $error("second request accepted while busy");
endmodule

bind fbmp_port fbmp_port_assertions u_chk (.*);

// ### testbench/fbmp_mem_model.sv
// behavioural memory word and boot store byte source on the shared lines
`timescale 1ns/100ps
module fbmp_mem_model (
  input wire logic mclk_i,
  input wire logic [2:0] stb_i,
  input wire logic rom_sel_n_i,
  input wire logic [15:0] mask_i,
  input wire logic [127:0] dq_i,
  output logic [127:0] dq_o
);
  import fbmp_pkg::*;
  logic [127:0] mem_q = 128'h0;
  logic [5:0] rd_cnt = 6'h00;
  wire rom_rd = !rom_sel_n_i && !dq_i[ROM_OE_BIT];
  // released lines show the inverse so a stale capture cannot pass
  always_comb begin
    dq_o = rd_cnt != 6'h00 ? mem_q : ~mem_q;
    if (rom_rd) dq_o[31:24] = dq_i[7:0] ^ dq_i[15:8];
  end
  // commands sampled mid memory clock, where they stand still
  always @(posedge mclk_i) begin
    if (stb_i == STB_RD) rd_cnt <= 6'h28;
    else if (rd_cnt != 6'h00) rd_cnt <= rd_cnt - 6'h01;
    if (stb_i == STB_WR) for (int i = 0; i < 16; i++) if (!mask_i[i]) mem_q[8*i+:8] <= dq_i[8*i+:8];
  end
endmodule

// ### testbench/test_fbmp_port.sv
// self-checking bench for the framebuffer memory port
`timescale 1ns/100ps
module test_fbmp_port;
  import fbmp_pkg::*;
  logic clk_i = 0, rst_n_i = 0, mem_clk_return_i = 0, host_reset_n_i = 0, req_valid_i = 0;
  logic req_bank_i = 0, req_chip_i = 0, clk_en_req_i = 0, req_ready_o, rd_valid_o, rom_valid_o;
  logic mem_addr_oe_o, mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_n_o, boot_store_select_n_o;
  logic mem_clk_bank0_o, mem_clk_bank1_o, mem_clk_loop_o, mem_clk_en_o;
  fbmp_cmd_t req_cmd_i = FBMP_CMD_NOP;
  logic [10:0] req_addr_i = 0, strap_pins = 0, mem_addr_o, strap_o;
  logic [15:0] req_rom_addr_i = 0, req_byte_en_i = 0, mem_byte_mask_o;
  logic [7:0] req_rom_byte_i = 0, rom_byte_o;
  logic [1:0] mem_select_n_o;
  logic [127:0] req_wdata_i = 0, rd_data_o, fb_data_o, fb_data_oe_o, drv;
  int failures = 0, total_checks = 0, seed = 37;
  fbmp_cmd_t cmds[4] = '{FBMP_CMD_ACT, FBMP_CMD_PRE, FBMP_CMD_REF, FBMP_CMD_MRS};
  logic [2:0] codes[4] = '{STB_ACT, STB_PRE, STB_REF, STB_MRS};
  wire [2:0] stb = {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_n_o};
  wire [127:0] fb_data_i = (fb_data_oe_o & fb_data_o) | (~fb_data_oe_o & drv);
  wire [10:0] mem_addr_i = mem_addr_oe_o ? mem_addr_o : strap_pins;
  fbmp_port uut (.*);
  fbmp_mem_model u_mem (.mclk_i(mem_clk_bank0_o), .stb_i(stb), .rom_sel_n_i(boot_store_select_n_o),
    .mask_i(mem_byte_mask_o), .dq_i(fb_data_o), .dq_o(drv));
  initial forever #4 clk_i = ~clk_i;
  // link clock unrelated in phase to the core clock
  initial begin
    #13;
    forever #32 mem_clk_return_i = ~mem_clk_return_i;
  end
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait step: a hang ends the run
  task automatic step(inout int n);
    @(negedge clk_i);
    n++;
    if (n > 400) begin
      failures++;
      end_sim();
    end
  endtask
  task automatic issue(input fbmp_cmd_t c);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1) step(n);
    req_cmd_i = c;
    req_valid_i = 1;
    @(negedge clk_i);
    req_valid_i = 0;
  endtask
  function automatic logic [127:0] merge(input logic [127:0] o, input logic [127:0] w, input logic [15:0] en);
    for (int i = 0; i < 16; i++) if (en[i]) o[8*i+:8] = w[8*i+:8];
    return o;
  endfunction
  initial begin
    int n;
    logic [127:0] exp;
    logic [10:0] strap;
    exp = '0;
    strap = 11'($random(seed)) | 11'h001;
    strap_pins = strap;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1;
    repeat (4) @(negedge clk_i);
    chk("strap", strap, strap_o);
    host_reset_n_i = 1;
    repeat (4) @(negedge clk_i);
    strap_pins = ~strap;
    repeat (6) @(negedge clk_i);
    chk("strap held", strap, strap_o);
    for (int k = 0; k < 4; k++) begin
      req_addr_i = 11'($random(seed));
      issue(cmds[k]);
      n = 0;
      while (stb === STB_NOP) step(n);
      chk("strobes", codes[k], stb);
      chk("address", req_addr_i, mem_addr_o);
    end
    for (int k = 0; k < 4; k++) begin
      req_wdata_i = {$random(seed), $random(seed), $random(seed), $random(seed)};
      req_byte_en_i = k == 0 ? 16'hFFFF : (k == 1 ? 16'h8001 : 16'($random(seed)));
      req_bank_i = 1'($random(seed));
      clk_en_req_i = 1'($random(seed));
      issue(FBMP_CMD_WR);
      n = 0;
      while (stb !== STB_WR) step(n);
      chk("write data", req_wdata_i, fb_data_o);
      chk("byte mask", 16'(~req_byte_en_i), mem_byte_mask_o);
      chk("bank select", req_bank_i, mem_select_n_o[1]);
      chk("clock enable", clk_en_req_i, mem_clk_en_o);
      exp = merge(exp, req_wdata_i, req_byte_en_i);
      issue(FBMP_CMD_RD);
      n = 0;
      while (rd_valid_o !== 1'b1) step(n);
      chk("read data", exp, rd_data_o);
    end
    for (int k = 0; k < 3; k++) begin
      req_rom_addr_i = k == 0 ? 16'hFFFF : 16'($random(seed));
      issue(FBMP_CMD_ROM_RD);
      n = 0;
      while (rom_valid_o !== 1'b1) step(n);
      chk("boot byte", req_rom_addr_i[7:0] ^ req_rom_addr_i[15:8], rom_byte_o);
    end
    req_rom_byte_i = 8'($random(seed));
    issue(FBMP_CMD_ROM_WR);
    n = 0;
    while (boot_store_select_n_o !== 1'b0) step(n);
    chk("boot write lines", {req_rom_byte_i, 6'h00, 2'h1, req_rom_addr_i}, fb_data_o[31:0] & 32'hFF03FFFF);
    chk("boot write drive", 128'hFF03FFFF, fb_data_oe_o);
    n = 0;
    while (req_ready_o !== 1'b1) step(n);
    // second host reset: sgram straps, so the chip selects decode per chip
    strap = 11'($random(seed)) & 11'h7FE;
    strap_pins = strap;
    clk_en_req_i = 1;
    host_reset_n_i = 0;
    repeat (8) @(negedge clk_i);
    chk("ready in host reset", 1'b0, req_ready_o);
    chk("address drive in host reset", 1'b0, mem_addr_oe_o);
    chk("clock enable in host reset", 1'b0, mem_clk_en_o);
    host_reset_n_i = 1;
    repeat (4) @(negedge clk_i);
    chk("strap again", strap, strap_o);
    for (int k = 0; k < 2; k++) begin
      req_chip_i = 1'(k);
      issue(FBMP_CMD_WR);
      n = 0;
      while (stb !== STB_WR) step(n);
      chk("chip select", req_chip_i ? 2'h1 : 2'h2, mem_select_n_o);
    end
    repeat (30) @(negedge clk_i);
    end_sim();
  end
endmodule
